// file: hw/rvs_regs.svh
// Register offsets, field positions and opcodes of the verify link
`ifndef RVS_REGS_SVH
`define RVS_REGS_SVH
// Task file offsets on the link
`define RVS_A_ERR      3'h1
`define RVS_A_CNT      3'h2
`define RVS_A_SN       3'h3
`define RVS_A_CL       3'h4
`define RVS_A_CH       3'h5
`define RVS_A_DH       3'h6
`define RVS_A_CMD      3'h7
// Opcodes
`define RVS_OP_V28     8'h40
`define RVS_OP_V28R    8'h41
`define RVS_OP_V48     8'h42
// Error register bits
`define RVS_E_UNC      6
`define RVS_E_IDNF     4
`define RVS_E_ABRT     2
// Status register bits
`define RVS_S_BSY      7
`define RVS_S_RDY      6
`define RVS_S_DSC      4
`define RVS_S_ERR      0
// Device/head bits
`define RVS_DH_L       6
`define RVS_DH_BASE    8'hA0
`define RVS_DH_EXT     8'hE0
// Host Avalon word indices
`define RVS_H_CTRL     4'h0
`define RVS_H_LBA_LO   4'h1
`define RVS_H_LBA_HI   4'h2
`define RVS_H_COUNT    4'h3
`define RVS_H_RES_LO   4'h4
`define RVS_H_RES_HI   4'h5
`define RVS_H_RES_INFO 4'h6
`define RVS_H_IRQ_STAT 4'h7
`define RVS_H_IRQ_MASK 4'h8
// Host control bits
`define RVS_C_GO       0
`define RVS_C_EXT      1
`define RVS_C_LBA      2
`define RVS_C_RETRY    3
// Host interrupt bits
`define RVS_I_DONE     0
`define RVS_I_ERR      1
`endif

// file: hw/rvs_pkg.sv
// State types of the drive end and of the host end of the verify link
package rvs_pkg;
  typedef enum {DEV_IDLE, DEV_ISSUE, DEV_WAIT} dev_state_t;
  typedef enum {H_IDLE, H_WRITE, H_WAIT, H_READ, H_CAPT} host_state_t;
endpackage

// file: hw/rvs_link_if.sv
// Task file link between host controller and drive
`timescale 1ns/10ps
`default_nettype none
interface rvs_link_if;
  logic       wr_en;
  logic       rd_en;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       hob;
  logic [7:0] rdata;
  logic       intrq;
  modport host_end (output wr_en, output rd_en, output addr, output wdata,
                    output hob, input rdata, input intrq);
  modport dev_end (input wr_en, input rd_en, input addr, input wdata,
                   input hob, output rdata, output intrq);
endinterface
`default_nettype wire

// file: hw/rvs_device.sv
// Drive end: task file and read-verify command engine
// Notes on behaviour
// - Opcodes 40h/41h verify, no data returned
// - Zero 28-bit count means 256 sectors
// - L=0: sector, cylinder, head give start
// - L=1: LBA bytes across four registers
// - Retry bit ignored, same behaviour
// - Count returns sectors left unverified
// - Address registers return last sector processed
// - Uncorrectable error stops at failing sector
// - Opcode 42h extended verify, no data
// - Extended count 16 bits, zero means 65536
// - Extended error ends at failing sector
// - HOB selects upper address bytes on read
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "rvs_regs.svh"
module rvs_device #(
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS             = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  rvs_link_if.dev_end      link,
  output logic             med_req,
  output logic [47:0]      med_addr,
  output logic             med_geo,
  input  wire logic        med_done,
  input  wire logic        med_unc,
  input  wire logic        med_idnf
);

  rvs_pkg::dev_state_t state;
  logic [7:0]  cnt_cur;
  logic [7:0]  cnt_prev;
  logic [7:0]  sn_cur;
  logic [7:0]  sn_prev;
  logic [7:0]  cl_cur;
  logic [7:0]  cl_prev;
  logic [7:0]  ch_cur;
  logic [7:0]  ch_prev;
  logic [7:0]  dev_head;
  logic [7:0]  err_reg;
  logic        err_flag;
  logic        ext;
  logic [47:0] pos;
  logic [16:0] remain;
  logic        cmd_wr;
  logic        cmd_ok;
  logic        fin;
  logic        fin_err;
  logic        abort;
  logic [7:0]  status;

  ////////////////////////////////////////////////////////////////////////
  // Decode and finish conditions

  assign cmd_wr = link.wr_en && link.addr == `RVS_A_CMD &&
                  state == rvs_pkg::DEV_IDLE;
  assign cmd_ok = link.wdata == `RVS_OP_V28 ||
                  link.wdata == `RVS_OP_V28R ||
                  link.wdata == `RVS_OP_V48;
  assign abort   = cmd_wr && !cmd_ok;
  assign fin_err = state == rvs_pkg::DEV_WAIT && med_done &&
                   (med_unc || med_idnf);
  assign fin     = fin_err || (state == rvs_pkg::DEV_WAIT && med_done &&
                   remain == 17'h0_0001);
  assign status  = {(state != rvs_pkg::DEV_IDLE), 1'b1, 1'b0, 1'b1,
                    3'b000, err_flag};

  // Geometric stepping wraps sector, then head, then cylinder
  function automatic logic [47:0] next_pos(input logic [47:0] p,
                                           input logic        geo);
    logic [47:0] n;
    n = p + 48'h0000_0000_0001;
    if (geo) begin
      n = p;
      if (p[7:0] >= 8'(SECTORS_PER_TRACK)) begin
        n[7:0] = 8'h01;
        if (p[27:24] >= 4'(HEADS - 1)) begin
          n[27:24] = 4'h0;
          n[23:8]  = p[23:8] + 16'h0001;
        end else begin
          n[27:24] = p[27:24] + 4'h1;
        end
      end else begin
        n[7:0] = p[7:0] + 8'h01;
      end
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Verify engine

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state    <= rvs_pkg::DEV_IDLE;
      ext      <= 1'b0;
      pos      <= 48'h0000_0000_0000;
      remain   <= 17'h0_0000;
      med_req  <= 1'b0;
      med_addr <= 48'h0000_0000_0000;
      med_geo  <= 1'b0;
    end else begin
      unique case (state)
        rvs_pkg::DEV_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            state <= rvs_pkg::DEV_ISSUE;
            if (link.wdata == `RVS_OP_V48) begin
              ext     <= 1'b1;
              med_geo <= 1'b0;
              pos     <= {ch_prev, cl_prev, sn_prev,
                          ch_cur, cl_cur, sn_cur};
              remain  <= ({cnt_prev, cnt_cur} == 16'h0000) ?
                         17'h1_0000 : {1'b0, cnt_prev, cnt_cur};
            end else begin
              ext     <= 1'b0;
              med_geo <= !dev_head[`RVS_DH_L];
              pos     <= {20'h0_0000, dev_head[3:0],
                          ch_cur, cl_cur, sn_cur};
              remain  <= (cnt_cur == 8'h00) ?
                         17'h0_0100 : {9'h000, cnt_cur};
            end
          end
        end
        rvs_pkg::DEV_ISSUE: begin
          med_req  <= 1'b1;
          med_addr <= pos;
          state    <= rvs_pkg::DEV_WAIT;
        end
        rvs_pkg::DEV_WAIT: begin
          if (med_done) begin
            med_req <= 1'b0;
            if (fin_err) begin
              state <= rvs_pkg::DEV_IDLE;
            end else begin
              remain <= remain - 17'h0_0001;
              if (fin) begin
                state <= rvs_pkg::DEV_IDLE;
              end else begin
                pos   <= next_pos(pos, med_geo);
                state <= rvs_pkg::DEV_ISSUE;
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Task file: host writes to count, sector and cylinder shift current into previous

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_cur  <= 8'h00;
      cnt_prev <= 8'h00;
      sn_cur   <= 8'h00;
      sn_prev  <= 8'h00;
      cl_cur   <= 8'h00;
      cl_prev  <= 8'h00;
      ch_cur   <= 8'h00;
      ch_prev  <= 8'h00;
      dev_head <= 8'h00;
    end else if (fin) begin
      // Failing sector or last verified sector, per outcome
      sn_cur   <= pos[7:0];
      cl_cur   <= pos[15:8];
      ch_cur   <= pos[23:16];
      sn_prev  <= pos[31:24];
      cl_prev  <= pos[39:32];
      ch_prev  <= pos[47:40];
      if (!ext) begin
        dev_head[3:0] <= pos[27:24];
      end
      // Failing sector counts as not verified
      cnt_cur  <= fin_err ? remain[7:0] : 8'h00;
      cnt_prev <= fin_err ? remain[15:8] : 8'h00;
    end else if (link.wr_en && state == rvs_pkg::DEV_IDLE) begin
      // Writes while busy are dropped to protect the result
      unique case (link.addr)
        `RVS_A_CNT: begin
          cnt_prev <= cnt_cur;
          cnt_cur  <= link.wdata;
        end
        `RVS_A_SN: begin
          sn_prev <= sn_cur;
          sn_cur  <= link.wdata;
        end
        `RVS_A_CL: begin
          cl_prev <= cl_cur;
          cl_cur  <= link.wdata;
        end
        `RVS_A_CH: begin
          ch_prev <= ch_cur;
          ch_cur  <= link.wdata;
        end
        `RVS_A_DH: dev_head <= link.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error and status

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_reg  <= 8'h00;
      err_flag <= 1'b0;
    end else if (cmd_wr) begin
      err_reg                <= 8'h00;
      err_reg[`RVS_E_ABRT]   <= !cmd_ok;
      err_flag               <= !cmd_ok;
    end else if (fin) begin
      err_reg[`RVS_E_UNC]    <= fin_err && med_unc;
      err_reg[`RVS_E_IDNF]   <= fin_err && med_idnf;
      err_flag               <= fin_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port and completion interrupt

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.rdata <= 8'h00;
    end else if (link.rd_en) begin
      unique case (link.addr)
        `RVS_A_ERR: link.rdata <= err_reg;
        `RVS_A_CNT: link.rdata <= link.hob ? cnt_prev : cnt_cur;
        `RVS_A_SN:  link.rdata <= link.hob ? sn_prev : sn_cur;
        `RVS_A_CL:  link.rdata <= link.hob ? cl_prev : cl_cur;
        `RVS_A_CH:  link.rdata <= link.hob ? ch_prev : ch_cur;
        `RVS_A_DH:  link.rdata <= dev_head;
        `RVS_A_CMD: link.rdata <= status;
        default:    link.rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.intrq <= 1'b0;
    end else if (fin || abort) begin
      link.intrq <= 1'b1;
    end else if (link.rd_en && link.addr == `RVS_A_CMD) begin
      link.intrq <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: hw/rvs_host.sv
// Host end: Avalon-MM registers driving the verify command sequence
`timescale 1ns/10ps
`default_nettype none
`include "rvs_regs.svh"
module rvs_host (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  rvs_link_if.host_end     link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  rvs_pkg::host_state_t state;
  logic [3:0]  ctrl;
  logic [47:0] lba;
  logic [15:0] count;
  logic [7:0]  res [10];
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [3:0]  step;
  logic [2:0]  w_addr;
  logic [7:0]  w_data;
  logic [2:0]  r_addr;
  logic        acc;
  logic        start;
  logic        done_ev;
  logic [31:0] res_lo;
  logic [15:0] res_hi;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the edge that takes the request

  assign acc   = (avs_read || avs_write) && !avs_waitrequest;
  assign start = acc && avs_write && avs_address == `RVS_H_CTRL &&
                 avs_writedata[`RVS_C_GO] && state == rvs_pkg::H_IDLE;
  assign done_ev = state == rvs_pkg::H_CAPT && !link.rd_en &&
                   step == (ctrl[`RVS_C_EXT] ? 4'd9 : 4'd6);
  assign res_lo = ctrl[`RVS_C_EXT] ? {res[7], res[5], res[4], res[3]} :
                  {4'h0, res[6][3:0], res[5], res[4], res[3]};
  assign res_hi = ctrl[`RVS_C_EXT] ? {res[9], res[8]} : 16'h0000;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `RVS_H_CTRL:     rd_mux = {27'h000_0000, ctrl[3:1],
                                 (state != rvs_pkg::H_IDLE), 1'b0};
      `RVS_H_LBA_LO:   rd_mux = lba[31:0];
      `RVS_H_LBA_HI:   rd_mux = {16'h0000, lba[47:32]};
      `RVS_H_COUNT:    rd_mux = {16'h0000, count};
      `RVS_H_RES_LO:   rd_mux = res_lo;
      `RVS_H_RES_HI:   rd_mux = {16'h0000, res_hi};
      `RVS_H_RES_INFO: rd_mux = {res[0], res[1], 8'h00, res[2]};
      `RVS_H_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat};
      `RVS_H_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Setup registers apart from the interrupt mask are frozen while a command runs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl     <= 4'h0;
      lba      <= 48'h0000_0000_0000;
      count    <= 16'h0000;
      irq_mask <= 2'b00;
    end else if (acc && avs_write) begin
      if (avs_address == `RVS_H_IRQ_MASK) begin
        irq_mask <= avs_writedata[1:0];
      end
      if (start) begin
        ctrl <= {avs_writedata[3:1], 1'b0};
      end
      if (state == rvs_pkg::H_IDLE) begin
        unique case (avs_address)
          `RVS_H_LBA_LO: lba[31:0]  <= avs_writedata;
          `RVS_H_LBA_HI: lba[47:32] <= avs_writedata[15:0];
          `RVS_H_COUNT:  count      <= avs_writedata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky events; a new event beats the read that clears
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= 2'b00;
      irq      <= 1'b0;
    end else begin
      irq_stat <= ((acc && avs_read && avs_address == `RVS_H_IRQ_STAT) ?
                   2'b00 : irq_stat) |
                  {done_ev && res[0][`RVS_S_ERR], done_ev};
      irq      <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link sequence

  always_comb begin
    w_addr = `RVS_A_CMD;
    w_data = 8'h00;
    unique case (step)
      4'd0: begin w_addr = `RVS_A_CNT; w_data = count[15:8]; end
      4'd1: begin w_addr = `RVS_A_SN;  w_data = lba[31:24];  end
      4'd2: begin w_addr = `RVS_A_CL;  w_data = lba[39:32];  end
      4'd3: begin w_addr = `RVS_A_CH;  w_data = lba[47:40];  end
      4'd4: begin w_addr = `RVS_A_CNT; w_data = count[7:0];  end
      4'd5: begin w_addr = `RVS_A_SN;  w_data = lba[7:0];    end
      4'd6: begin w_addr = `RVS_A_CL;  w_data = lba[15:8];   end
      4'd7: begin w_addr = `RVS_A_CH;  w_data = lba[23:16];  end
      4'd8: begin
        w_addr = `RVS_A_DH;
        w_data = ctrl[`RVS_C_EXT] ? `RVS_DH_EXT :
                 (`RVS_DH_BASE | {1'b0, ctrl[`RVS_C_LBA], 2'b00, lba[27:24]});
      end
      default: begin
        w_data = ctrl[`RVS_C_EXT] ? `RVS_OP_V48 :
                 (`RVS_OP_V28 | {7'h00, ctrl[`RVS_C_RETRY]});
      end
    endcase
  end

  always_comb begin
    unique case (step)
      4'd0:    r_addr = `RVS_A_CMD;
      4'd1:    r_addr = `RVS_A_ERR;
      4'd2:    r_addr = `RVS_A_CNT;
      4'd3:    r_addr = `RVS_A_SN;
      4'd4:    r_addr = `RVS_A_CL;
      4'd5:    r_addr = `RVS_A_CH;
      4'd6:    r_addr = `RVS_A_DH;
      4'd7:    r_addr = `RVS_A_SN;
      4'd8:    r_addr = `RVS_A_CL;
      default: r_addr = `RVS_A_CH;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state      <= rvs_pkg::H_IDLE;
      step       <= 4'd0;
      link.wr_en <= 1'b0;
      link.rd_en <= 1'b0;
      link.addr  <= 3'h0;
      link.wdata <= 8'h00;
      link.hob   <= 1'b0;
      for (int i = 0; i < 10; i++) begin
        res[i] <= 8'h00;
      end
    end else begin
      link.wr_en <= 1'b0;
      link.rd_en <= 1'b0;
      unique case (state)
        rvs_pkg::H_IDLE: begin
          if (start) begin
            step  <= avs_writedata[`RVS_C_EXT] ? 4'd0 : 4'd4;
            state <= rvs_pkg::H_WRITE;
          end
        end
        rvs_pkg::H_WRITE: begin
          link.wr_en <= 1'b1;
          link.addr  <= w_addr;
          link.wdata <= w_data;
          if (step == 4'd9) begin
            state <= rvs_pkg::H_WAIT;
          end else begin
            step <= step + 4'd1;
          end
        end
        rvs_pkg::H_WAIT: begin
          if (link.intrq && !link.wr_en) begin
            step  <= 4'd0;
            state <= rvs_pkg::H_READ;
          end
        end
        rvs_pkg::H_READ: begin
          link.rd_en <= 1'b1;
          link.addr  <= r_addr;
          link.hob   <= step >= 4'd7;
          state      <= rvs_pkg::H_CAPT;
        end
        rvs_pkg::H_CAPT: begin
          // Read data stands only from the edge after the strobe
          if (!link.rd_en) begin
            res[step] <= link.rdata;
            if (done_ev) begin
              link.hob <= 1'b0;
              state    <= rvs_pkg::H_IDLE;
            end else begin
              step  <= step + 4'd1;
              state <= rvs_pkg::H_READ;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: test/rvs_link_properties.sv
// Checker of the task file link between host and drive ends
`timescale 1ns/10ps
`default_nettype none
`include "rvs_regs.svh"
module rvs_link_properties (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       hob,
  input wire logic [7:0] rdata,
  input wire logic       intrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  sequence s_cmd;
    wr_en && addr == `RVS_A_CMD;
  endsequence
  sequence s_dh_cmd;
    wr_en && addr == `RVS_A_DH ##1 s_cmd;
  endsequence
  sequence s_stat_read;
    rd_en && addr == `RVS_A_CMD && intrq;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_ONE_DIR: assert property (!(wr_en && rd_en))
    else $error("read and write strobes together");
  AST_OPCODE: assert property (s_cmd |->
    wdata inside {`RVS_OP_V28, `RVS_OP_V28R, `RVS_OP_V48})
    else $error("unknown opcode issued");
  AST_DH: assert property (s_dh_cmd |->
    $past(wdata[7]) && $past(wdata[5]) &&
    (wdata != `RVS_OP_V48 || $past(wdata) == `RVS_DH_EXT))
    else $error("device head byte wrong before command");
  AST_ORDER: assert property (s_cmd |->
    $past(addr, 5) == `RVS_A_CNT && $past(addr, 2) == `RVS_A_CH &&
    (wdata != `RVS_OP_V48 || $past(addr, 9) == `RVS_A_CNT))
    else $error("task file load order wrong");
  AST_QUIET: assert property (s_cmd |=> !intrq [*2])
    else $error("completion too soon after command");
  AST_INTRQ_HOLD: assert property (intrq &&
    !(rd_en && addr == `RVS_A_CMD) |=> intrq)
    else $error("completion dropped without status read");
  AST_INTRQ_CLR: assert property (s_stat_read |-> ##[1:2] !intrq)
    else $error("completion not cleared by status read");
  AST_STATUS: assert property (s_stat_read |=> rdata[7:1] == 7'h28)
    else $error("status bits wrong at completion");
  AST_ERRBITS: assert property (rd_en && addr == `RVS_A_ERR |=>
    (rdata & 8'hAB) == 8'h00)
    else $error("reserved error bits set");
  AST_NO_DATA: assert property (rd_en |-> addr != 3'h0)
    else $error("data register read during verify");
  AST_HOB_READ: assert property (rd_en && hob |->
    addr inside {`RVS_A_SN, `RVS_A_CL, `RVS_A_CH})
    else $error("upper byte select on wrong register");
  AST_HOLD: assert property (!rd_en |=> $stable(rdata))
    else $error("read data changed without read");
endmodule
`default_nettype wire

// file: test/test_read_verify_sectors_cmd.sv
// Testbench joining host and drive ends with a medium model
`timescale 1ns/10ps
`default_nettype none
`include "rvs_regs.svh"
module test_read_verify_sectors_cmd;
  logic        clk_sys;
  logic        rst_b;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        med_req;
  logic [47:0] med_addr;
  logic        med_geo;
  logic        med_done;
  logic        med_unc;
  logic        med_idnf;
  logic [47:0] first_addr;
  logic        geo_seen;
  logic [31:0] rd;
  logic        fail_idnf;
  int          n_sec;
  int          fail_at;
  int          n_fail;
  int          checks_done;
  int          cyc = 0;
  rvs_link_if link_bus ();
  rvs_device i_rvs_device (.clk_sys(clk_sys), .rst_b(rst_b), .link(link_bus),
    .med_req(med_req), .med_addr(med_addr), .med_geo(med_geo),
    .med_done(med_done), .med_unc(med_unc), .med_idnf(med_idnf));
  rvs_host i_rvs_host (.clk_sys(clk_sys), .rst_b(rst_b), .link(link_bus),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  rvs_link_properties i_rvs_link_properties (.clk_sys(clk_sys),
    .rst_b(rst_b), .wr_en(link_bus.wr_en), .rd_en(link_bus.rd_en),
    .addr(link_bus.addr), .wdata(link_bus.wdata), .hob(link_bus.hob),
    .rdata(link_bus.rdata), .intrq(link_bus.intrq));
  ////////////////////////////////////////////////////////////////////////
  // Medium answers one cycle after each request; one chosen sector fails
  always @(posedge clk_sys) begin
    med_done <= 1'b0;
    med_unc <= 1'b0;
    med_idnf <= 1'b0;
    if (rst_b && med_req && !med_done) begin
      if (n_sec == 0) first_addr <= med_addr;
      geo_seen <= med_geo;
      med_done <= 1'b1;
      med_unc <= (n_sec == fail_at) && !fail_idnf;
      med_idnf <= (n_sec == fail_at) && fail_idnf;
      n_sec <= n_sec + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leading edge keeps the release and the next request apart
  task automatic av_xfer(input logic wr, input logic [3:0] a,
                         input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic run_cmd(input logic [3:0] ctl, input logic [47:0] lba,
                         input logic [15:0] cnt, input int fa);
    n_sec = 0;
    fail_at = fa;
    av_xfer(1'b1, `RVS_H_LBA_LO, lba[31:0]);
    av_xfer(1'b1, `RVS_H_LBA_HI, {16'h0000, lba[47:32]});
    av_xfer(1'b1, `RVS_H_COUNT, {16'h0000, cnt});
    av_xfer(1'b1, `RVS_H_IRQ_MASK, 32'h0000_0003);
    av_xfer(1'b1, `RVS_H_CTRL, {28'h000_0000, ctl});
    while (irq !== 1'b1) @(posedge clk_sys);
  endtask
  task automatic check_res(input logic [47:0] a, input logic [7:0] c, e, s,
                           input int ns);
    chk("sectors", ns, n_sec);
    av_xfer(1'b0, `RVS_H_RES_LO, 32'h0000_0000);
    chk("res_lo", a[31:0], rd);
    av_xfer(1'b0, `RVS_H_RES_HI, 32'h0000_0000);
    chk("res_hi", {16'h0000, a[47:32]}, rd);
    av_xfer(1'b0, `RVS_H_RES_INFO, 32'h0000_0000);
    chk("res_info", {s, e, 8'h00, c}, rd);
    av_xfer(1'b0, `RVS_H_IRQ_STAT, 32'h0000_0000);
    chk("irq_err", s[0], rd[1]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_lba28;
    for (int r = 0; r < 2; r++) begin
      run_cmd({r[0], 3'h5}, 48'h0000_00AB_CDEF, 16'h0003, -1);
      check_res(48'h0000_00AB_CDF1, 8'h00, 8'h00, 8'h50, 3);
      chk("first", 32'h00AB_CDEF, first_addr[31:0]);
      chk("geo", 0, geo_seen);
    end
    $display("test lba28 done");
  endtask
  task automatic t_zero28;
    run_cmd(4'h5, 48'h0000_0000_0100, 16'h0000, -1);
    check_res(48'h0000_0000_01FF, 8'h00, 8'h00, 8'h50, 256);
    $display("test zero28 done");
  endtask
  // Last sector of the last head wraps to the next cylinder
  task automatic t_geo;
    run_cmd(4'h1, 48'h0000_0F00_053E, 16'h0003, -1);
    chk("first", 32'h0F00_053E, first_addr[31:0]);
    chk("geo", 1, geo_seen);
    check_res(48'h0000_0000_0601, 8'h00, 8'h00, 8'h50, 3);
    $display("test geo done");
  endtask
  task automatic t_fail28;
    fail_idnf = 1'b1;
    run_cmd(4'h5, 48'h0000_0000_0100, 16'h0005, 1);
    check_res(48'h0000_0000_0101, 8'h04, 8'h10, 8'h51, 2);
    fail_idnf = 1'b0;
    $display("test fail28 done");
  endtask
  task automatic t_ext;
    run_cmd(4'h7, 48'h1234_5678_9ABC, 16'h0104, 256);
    chk("first_hi", 32'h0000_1234, {16'h0000, first_addr[47:32]});
    check_res(48'h1234_5678_9BBC, 8'h04, 8'h40, 8'h51, 257);
    run_cmd(4'h7, 48'h0000_0000_0010, 16'h0000, 5);
    check_res(48'h0000_0000_0015, 8'hFB, 8'h40, 8'h51, 6);
    $display("test ext done");
  endtask
  task automatic t_irq;
    run_cmd(4'h5, 48'h0000_0000_0020, 16'h0001, -1);
    av_xfer(1'b1, `RVS_H_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk("irq_masked", 0, irq);
    av_xfer(1'b1, `RVS_H_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("irq_unmasked", 1, irq);
    av_xfer(1'b0, `RVS_H_IRQ_STAT, 32'h0000_0000);
    chk("irq_stat", 32'h0000_0001, rd);
    repeat (2) @(posedge clk_sys);
    chk("irq_cleared", 0, irq);
    av_xfer(1'b0, `RVS_H_IRQ_STAT, 32'h0000_0000);
    chk("irq_stat_clr", 32'h0000_0000, rd);
    av_xfer(1'b0, 4'hF, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    $display("test irq done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    rst_b = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {n_fail, checks_done, n_sec, fail_idnf} = '0;
    fail_at = -1;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_lba28();
    t_zero28();
    t_geo();
    t_fail28();
    t_ext();
    t_irq();
    complete_run();
  end
endmodule
`default_nettype wire
